// *** bench/sphr_coil_model.sv ***
/*
  Pushbutton and coil power stage of one channel.
  Bench sets button, fault and coil current level.
*/
`timescale 1ns/1ns
module sphr_coil_model
(
  // Bench controls
  input  wire logic       press,
  input  wire logic       inject,
  input  wire logic [7:0] level,
  // Device side
  input  wire logic       stage_sleep,
  output logic            request,
  output logic [7:0]      sense,
  output logic            fault
);
  // Sleeping stage carries no coil current
  assign sense   = stage_sleep ? 8'h00 : level;
  assign request = press;
  assign fault   = inject;
endmodule

// *** bench/sphr_top_properties.sv ***
/*
  Port assertions for sphr_top, bound into every instance.
  Assumes the top ports and the synchronous active-high reset.
*/
`timescale 1ns/1ns
module sphr_checker
  import sphr_pkg::*;
#(
  parameter int unsigned SLOW_DIV_P      = SLOW_DIV,
  parameter int unsigned STARTUP_TICKS_P = STARTUP_TICKS
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Coil pins
  input wire logic coil_request_a,
  input wire logic stage_fault_a,
  input wire logic high_side_out_a,
  input wire logic low_side_out_a,
  input wire logic low_side_out_b,
  input wire logic stage_sleep_a,
  input wire logic output_drive_enable0_a,
  input wire logic output_drive_enable1_b,
  input wire logic status_out_a,
  input wire logic fault_out_a,
  input wire logic fault_out_b,
  input wire logic fault_oe_n_a,
  // Shared
  input wire logic ready
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  // Length of the current high-side run, saturating
  logic [9:0] hi_q;
  always_ff @(posedge clk)
  begin
    if (reset || !high_side_out_a)
      hi_q <= 10'h000;
    else if (hi_q != 10'h3ff)
      hi_q <= hi_q + 10'h001;
  end

  property p_low_side;
    !low_side_out_a && !low_side_out_b;
  endproperty
  a_low_side: assert property (p_low_side) else $error("low side driven");
  property p_wake;
    coil_request_a |=> !stage_sleep_a;
  endproperty
  a_wake: assert property (p_wake) else $error("stage still asleep");
  property p_enable;
    !ready |-> !output_drive_enable0_a && !output_drive_enable1_b;
  endproperty
  a_enable: assert property (p_enable) else $error("drive enabled early");
  property p_hs_off;
    (!ready || !coil_request_a) |=> !high_side_out_a;
  endproperty
  a_hs_off: assert property (p_hs_off) else $error("high side while idle");
  property p_ready;
    ready |=> ready;
  endproperty
  a_ready: assert property (p_ready) else $error("ready dropped");
  property p_fault_oe;
    stage_fault_a |-> ##2 !fault_oe_n_a;
  endproperty
  a_fault_oe: assert property (p_fault_oe) else $error("fault pin not pulled");
  property p_fault_pin;
    !fault_out_a && !fault_out_b;
  endproperty
  a_fault_pin: assert property (p_fault_pin) else $error("fault pin high");
  property p_status;
    (!stage_fault_a) [*4] |=> status_out_a == $past(coil_request_a);
  endproperty
  a_status: assert property (p_status) else $error("status not request");
  property p_blank;
    $fell(high_side_out_a) && $past(coil_request_a) |-> hi_q >= 10'd370;
  endproperty
  a_blank: assert property (p_blank) else $error("on-time too short");
endmodule

bind sphr_top sphr_checker #(
  .SLOW_DIV_P      (SLOW_DIV_P),
  .STARTUP_TICKS_P (STARTUP_TICKS_P)
) u_checker (
  .clk                    (clk),
  .reset                  (reset),
  .coil_request_a         (coil_request_a),
  .stage_fault_a          (stage_fault_a),
  .high_side_out_a        (high_side_out_a),
  .low_side_out_a         (low_side_out_a),
  .low_side_out_b         (low_side_out_b),
  .stage_sleep_a          (stage_sleep_a),
  .output_drive_enable0_a (output_drive_enable0_a),
  .output_drive_enable1_b (output_drive_enable1_b),
  .status_out_a           (status_out_a),
  .fault_out_a            (fault_out_a),
  .fault_out_b            (fault_out_b),
  .fault_oe_n_a           (fault_oe_n_a),
  .ready                  (ready)
);

// *** bench/sphr_top_tb.sv ***
/*
  Self-checking bench for sphr_top with two coil models.
  Short oscillator and start-up counts keep the run brief.
*/
`timescale 1ns/1ns
module sphr_top_tb;
  logic       clk;
  logic       reset;
  logic       rf_write;
  logic [3:0] rf_addr;
  logic [7:0] rf_wdata;
  logic [1:0] press;
  logic [1:0] inject;
  logic [7:0] level [2];
  wire  [7:0] rf_rdata, sa, sb;
  wire  [1:0] req, flt, hs, ls, slp, en0, en1, st, fo, foe;
  wire        ready, cpc, lfs;
  int         n_fail = 0;
  int         checks = 0;

  sphr_coil_model u_coil_a (.press(press[0]), .inject(inject[0]), .level(level[0]),
    .stage_sleep(slp[0]), .request(req[0]), .sense(sa), .fault(flt[0]));
  sphr_coil_model u_coil_b (.press(press[1]), .inject(inject[1]), .level(level[1]),
    .stage_sleep(slp[1]), .request(req[1]), .sense(sb), .fault(flt[1]));
  sphr_top #(.SLOW_DIV_P(8), .STARTUP_TICKS_P(4)) DUT (
    .clk(clk), .reset(reset),
    .coil_request_a(req[0]), .sense_a(sa), .stage_fault_a(flt[0]),
    .high_side_out_a(hs[0]), .low_side_out_a(ls[0]), .stage_sleep_a(slp[0]),
    .output_drive_enable0_a(en0[0]), .output_drive_enable1_a(en1[0]),
    .status_out_a(st[0]), .fault_out_a(fo[0]), .fault_oe_n_a(foe[0]),
    .coil_request_b(req[1]), .sense_b(sb), .stage_fault_b(flt[1]),
    .high_side_out_b(hs[1]), .low_side_out_b(ls[1]), .stage_sleep_b(slp[1]),
    .output_drive_enable0_b(en0[1]), .output_drive_enable1_b(en1[1]),
    .status_out_b(st[1]), .fault_out_b(fo[1]), .fault_oe_n_b(foe[1]),
    .ready(ready), .charge_pump_clk(cpc), .lf_square(lfs),
    .rf_write(rf_write), .rf_addr(rf_addr), .rf_wdata(rf_wdata), .rf_rdata(rf_rdata));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic rf_wr(input logic [3:0] a, input logic [7:0] d);
    rf_addr = a;
    rf_wdata = d;
    rf_write = 1'b1;
    cyc(1);
    rf_write = 1'b0;
  endtask
  task automatic rf_rd(input logic [3:0] a, input logic [7:0] e);
    rf_addr = a;
    cyc(2);
    check(16'(rf_rdata), 16'(e));
  endtask
  task automatic hi_count(input int c, input int n, output int k);
    k = 0;
    repeat (n)
    begin
      @(negedge clk);
      k += int'(hs[c] === 1'b1);
    end
  endtask
  // Cycles until the status (w=1) or square wave (w=0) flips
  task automatic gap(input int c, input bit w, output int t);
    logic v;
    v = w ? st[c] : lfs;
    t = 0;
    while ((w ? st[c] : lfs) === v && t < 9000)
    begin
      cyc(1);
      t++;
    end
  endtask
  task automatic run(input int c);
    int k;
    int t;
    level[c] = 8'h19;
    press[c] = 1'b1;
    cyc(2);
    check(16'(slp[c]), 16'h0);
    check(16'(st[c]), 16'h1);
    t = 0;
    while (ready !== 1'b1 && t < 300)
    begin
      cyc(1);
      t++;
    end
    check(16'(ready), 16'h1);
    if (c == 0)
      check(16'(t >= 60 && t <= 100), 16'h1);
    // Drive enables are a registered copy of ready
    cyc(1);
    check(16'({en0[c], en1[c]}), 16'h3);
    k = 0;
    repeat (50)
    begin
      @(negedge clk);
      k += int'(cpc === 1'b1);
    end
    check(16'(k), 16'd10);
    cyc(20);
    hi_count(c, 600, k);
    check(16'(k), 16'(600));
    check(16'(hs[1 - c]), 16'h0);
    cyc(400);
    hi_count(c, 2560, k);
    check(16'(k >= 745 && k <= 755), 16'h1);
    level[c] = 8'h00;
    cyc(1280);
    hi_count(c, 1280, k);
    check(16'(k), 16'(1280));
    gap(c, 1'b0, t);
    gap(c, 1'b0, t);
    check(16'(t >= 254 && t <= 258), 16'h1);
    press[c] = 1'b0;
    cyc(2);
    check(16'({hs[c], slp[c], st[c]}), 16'h2);
    level[c] = 8'h19;
    press[c] = 1'b1;
    cyc(20);
    hi_count(c, 600, k);
    check(16'(k), 16'(600));
    inject[c] = 1'b1;
    cyc(3);
    check(16'({foe[c], fo[c], ls[c]}), 16'h0);
    gap(c, 1'b1, t);
    gap(c, 1'b1, t);
    check(16'(t >= 8188 && t <= 8196), 16'h1);
    inject[c] = 1'b0;
    cyc(3);
    check(16'(foe[c]), 16'h1);
    press[c] = 1'b0;
    cyc(5);
    $display("test channel %0d done", c);
  endtask
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial
  begin
    int k;
    reset = 1'b1;
    rf_write = 1'b0;
    rf_addr = 4'h0;
    rf_wdata = 8'h00;
    press = 2'b00;
    inject = 2'b00;
    level[0] = 8'h00;
    level[1] = 8'h00;
    cyc(10);
    reset = 1'b0;
    rf_rd(4'h0, 8'hfe);
    rf_rd(4'h1, 8'hc3);
    rf_rd(4'h8, 8'hda);
    rf_rd(4'h9, 8'hc4);
    rf_rd(4'h5, 8'h00);
    rf_wr(4'h5, 8'ha5);
    rf_rd(4'h5, 8'ha5);
    $display("test registers done");
    k = 0;
    repeat (40)
    begin
      @(negedge clk);
      k += int'(cpc === 1'b1);
    end
    check(16'(k), 16'h0);
    check(16'({ready, slp, foe, hs, en0, en1}), 16'h3c0);
    $display("test idle done");
    run(0);
    run(1);
    conclude();
  end
  // Watchdog well beyond the expected run length
  initial
  begin
    repeat (80000) @(posedge clk);
    n_fail++;
    conclude();
  end
endmodule

// *** design/sphr_channel.sv ***
/*
  One regulator channel: power stage control, reference sequencer,
  blanking timer, current comparator and chopper, fault and status.
  Expects one-cycle tick strobes from the top-level oscillators.
*/
`timescale 1ns/1ns
module sphr_channel
  import sphr_pkg::*;
(
  // Clock and reset
  input  wire logic           clk,
  input  wire logic           reset,
  // Timebase
  input  wire logic           ready,
  input  wire logic           fast_tick,
  input  wire logic           slow_tick,
  input  wire logic           blink,
  // Reference bytes
  input  wire logic [7:0]     peak_ref,
  input  wire logic [7:0]     hold_ref,
  // Pins
  input  wire sphr_chan_in_t  pin_in,
  output sphr_chan_out_t      pin_out
);

  logic        hold_q;
  logic [7:0]  peak_cnt_q;
  logic [7:0]  pwm_cnt_q;
  logic [7:0]  blank_cnt_q;
  logic        trip_q;
  logic        fault_q;
  sphr_chan_out_t out_q;

  wire         active     = pin_in.request & ready;
  wire         strobe     = active & fast_tick & (pwm_cnt_q == 8'h00);
  wire         blanking   = (blank_cnt_q != 8'h00);
  wire  [7:0]  cur_ref    = hold_q ? hold_ref : peak_ref;
  wire  [10:0] sense_amp  = {3'b000, pin_in.sense} << SENSE_GAIN_SH;
  wire         over       = sense_amp > {3'b000, cur_ref};
  wire         peak_done  = slow_tick & (peak_cnt_q == 8'(PEAK_TICKS - 1));
  wire         chop       = active & (blanking | strobe | ~(trip_q | over));

  // Peak interval then a single step to hold
  always_ff @(posedge clk)
  begin
    if (reset || !active)
    begin
      hold_q     <= 1'b0;
      peak_cnt_q <= 8'h00;
    end
    else if (!hold_q && slow_tick)
    begin
      peak_cnt_q <= peak_cnt_q + 8'h01;
      if (peak_done)
        hold_q <= 1'b1;
    end
  end

  // Chopper cycle and 3 us blanking after each strobe
  always_ff @(posedge clk)
  begin
    if (reset || !active)
    begin
      pwm_cnt_q   <= 8'h00;
      blank_cnt_q <= 8'h00;
    end
    else if (fast_tick)
    begin
      pwm_cnt_q <= pwm_cnt_q + 8'h01;
      if (strobe)
        blank_cnt_q <= 8'(BLANK_TICKS);
      else if (blanking)
        blank_cnt_q <= blank_cnt_q - 8'h01;
    end
  end

  // Trip latch; comparator ignored while blanking
  always_ff @(posedge clk)
  begin
    if (reset || !active || strobe)
      trip_q <= 1'b0;
    else if (over && !blanking)
      trip_q <= 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      fault_q <= 1'b0;
      out_q   <= '{default: 1'b0, stage_sleep: 1'b1, fault_oe_n: 1'b1};
    end
    else
    begin
      fault_q             <= pin_in.fault;
      out_q.high_side     <= chop;
      out_q.low_side      <= 1'b0;
      out_q.stage_sleep   <= ~pin_in.request;
      out_q.drive_enable0 <= ready;
      out_q.drive_enable1 <= ready;
      out_q.status        <= fault_q ? blink : pin_in.request;
      out_q.fault_oe_n    <= ~fault_q;
      out_q.hold          <= hold_q;
    end
  end

  assign pin_out = out_q;

endmodule

// *** design/sphr_pkg.sv ***
/*
  Shared constants and carrier types for the two-channel peak-and-hold
  solenoid regulator. Assumes a 125 MHz system clock.
*/
package sphr_pkg;

  // System and oscillator rates
  localparam int unsigned CLK_HZ       = 125_000_000;
  localparam int unsigned FAST_HZ      = 25_000_000;
  localparam int unsigned SLOW_MHZ     = 2_048_000;   // milli-hertz, 2.048 kHz
  localparam int unsigned FAST_DIV     = CLK_HZ / FAST_HZ;
  localparam int unsigned SLOW_DIV     = int'((64'(CLK_HZ) * 1000) / SLOW_MHZ);
  localparam int unsigned SQUARE_DIV   = 64;
  localparam int unsigned STARTUP_PRE  = 4;

  // Times as printed and their tick counts
  localparam int unsigned STARTUP_US   = 2000;
  localparam int unsigned STARTUP_TICKS = (STARTUP_US * (FAST_HZ / 1_000_000)) / STARTUP_PRE;
  localparam int unsigned BLANK_NS     = 3000;
  localparam int unsigned BLANK_TICKS  = (BLANK_NS * (FAST_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned PEAK_MS      = 50;
  localparam int unsigned PEAK_TICKS   = (PEAK_MS * SLOW_MHZ + 999_999) / 1_000_000;
  localparam int unsigned BLINK_HZ     = 1;
  localparam int unsigned BLINK_HALF   = SLOW_MHZ / 1000 / BLINK_HZ / 2;
  localparam int unsigned PWM_PERIOD   = 256;         // fast ticks per chopper cycle

  localparam int unsigned SENSE_GAIN_SH = 3;          // gain of 8

  // Register file
  localparam int unsigned RF_BYTES     = 16;
  localparam logic [3:0] COIL_B_PEAK_REF_OFS = 4'h0;
  localparam logic [3:0] COIL_B_HOLD_REF_OFS = 4'h1;
  localparam logic [3:0] COIL_A_PEAK_REF_OFS = 4'h8;
  localparam logic [3:0] COIL_A_HOLD_REF_OFS = 4'h9;
  localparam logic [7:0] COIL_B_PEAK_REF_RST = 8'hfe;
  localparam logic [7:0] COIL_B_HOLD_REF_RST = 8'hc3;
  localparam logic [7:0] COIL_A_PEAK_REF_RST = 8'hda;
  localparam logic [7:0] COIL_A_HOLD_REF_RST = 8'hc4;

  typedef struct packed {
    logic       request;
    logic       fault;
    logic [7:0] sense;
  } sphr_chan_in_t;

  typedef struct packed {
    logic high_side;
    logic low_side;
    logic stage_sleep;
    logic drive_enable0;
    logic drive_enable1;
    logic status;
    logic fault_oe_n;
    logic hold;
  } sphr_chan_out_t;

endpackage

// *** design/sphr_top.sv ***
/*
  Two-channel peak-and-hold solenoid regulator: oscillators, start-up
  delay, reference register file and two independent channels.
  Command, sense and fault inputs are synchronous to clk.
*/
`timescale 1ns/1ns
// Behaviour
// - Slow oscillator 2.048 kHz, undivided, times the peak interval.
// - Low-frequency square wave comes from slow oscillator divided by 64.
// - Both oscillators run only while a coil command is high.
// - Fast oscillator 25 MHz clocks blanking and the charge pump clock.
// - Start-up counter uses fast oscillator divided by four.
// - After reset, ready rises after about 2 ms of running fast oscillator (a coil command high); it gates power output.
// - Stage sleeps while command low; inverted command drives sleep.
// - Output drive enables follow ready only.
// - Low-side input held low; high side follows chopper only.
// - Each stage gives its own fault signal.
// - Second channel is an identical independent copy.
// - Chopper passes high drive, cut when sensed current exceeds reference.
// - Each strobe gives 3 us blanking where comparator is ignored.
// - Channel A uses byte 8 for peak, byte 9 for hold.
// - Step edge advances reference byte index by one.
// - 50 ms after enable the sequencer steps to hold.
// - Sequencer and stage run when command high after ready, stop at once.
// - Sense is multiplied by eight before comparison.
// - Channel B uses byte 0 for peak, byte 1 for hold.
// - Slow-oscillator divider makes the 1 Hz blink wave.
// - Faults registered; fault pins open-drain, status pins push-pull.
// - Status follows enable without fault, blinks 1 Hz with fault.
module sphr_top
  import sphr_pkg::*;
#(
  parameter int unsigned SLOW_DIV_P      = SLOW_DIV,
  parameter int unsigned STARTUP_TICKS_P = STARTUP_TICKS
)
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // Coil A pins
  input  wire logic        coil_request_a,
  input  wire logic [7:0]  sense_a,
  input  wire logic        stage_fault_a,
  output logic             high_side_out_a,
  output logic             low_side_out_a,
  output logic             stage_sleep_a,
  output logic             output_drive_enable0_a,
  output logic             output_drive_enable1_a,
  output logic             status_out_a,
  output logic             fault_out_a,
  output logic             fault_oe_n_a,
  // Coil B pins
  input  wire logic        coil_request_b,
  input  wire logic [7:0]  sense_b,
  input  wire logic        stage_fault_b,
  output logic             high_side_out_b,
  output logic             low_side_out_b,
  output logic             stage_sleep_b,
  output logic             output_drive_enable0_b,
  output logic             output_drive_enable1_b,
  output logic             status_out_b,
  output logic             fault_out_b,
  output logic             fault_oe_n_b,
  // Shared outputs
  output logic             ready,
  output logic             charge_pump_clk,
  output logic             lf_square,
  // Reference register file port
  input  wire logic        rf_write,
  input  wire logic [3:0]  rf_addr,
  input  wire logic [7:0]  rf_wdata,
  output logic [7:0]       rf_rdata
);

  logic [7:0]  rf_q [RF_BYTES];
  logic [7:0]  rf_rdata_q;
  logic [2:0]  fast_cnt_q;
  logic        fast_tick_q;
  logic [15:0] slow_cnt_q;
  logic        slow_tick_q;
  logic [5:0]  square_cnt_q;
  logic        square_q;
  logic [9:0]  blink_cnt_q;
  logic        blink_q;
  logic [1:0]  pre_cnt_q;
  logic [15:0] startup_cnt_q;
  logic        ready_q;
  logic        pump_q;
  logic        fault_pin_q;

  sphr_chan_in_t  chan_in  [2];
  sphr_chan_out_t chan_out [2];
  logic [7:0]     peak_ref [2];
  logic [7:0]     hold_ref [2];

  // Oscillator phase restarts from zero whenever both commands drop
  wire osc_enable   = coil_request_a | coil_request_b;
  wire fast_wrap    = (fast_cnt_q == 3'(FAST_DIV - 1));
  wire slow_wrap    = (slow_cnt_q == 16'(SLOW_DIV_P - 1));
  wire startup_done = (startup_cnt_q == 16'(STARTUP_TICKS_P - 1));
  wire pre_wrap     = (pre_cnt_q == 2'(STARTUP_PRE - 1));
  wire blink_wrap   = (blink_cnt_q == 10'(BLINK_HALF - 1));
  wire square_flip  = (square_cnt_q == 6'(SQUARE_DIV / 2 - 1)) ||
                      (square_cnt_q == 6'(SQUARE_DIV - 1));
  wire [7:0] rf_pick = rf_q[rf_addr];

  // Fast oscillator as a 25 MHz tick
  always_ff @(posedge clk)
  begin
    if (reset || !osc_enable)
    begin
      fast_cnt_q  <= 3'h0;
      fast_tick_q <= 1'b0;
    end
    else
    begin
      fast_cnt_q  <= fast_wrap ? 3'h0 : fast_cnt_q + 3'h1;
      fast_tick_q <= fast_wrap;
    end
  end

  // Slow oscillator as a 2.048 kHz tick
  always_ff @(posedge clk)
  begin
    if (reset || !osc_enable)
    begin
      slow_cnt_q  <= 16'h0000;
      slow_tick_q <= 1'b0;
    end
    else
    begin
      slow_cnt_q  <= slow_wrap ? 16'h0000 : slow_cnt_q + 16'h0001;
      slow_tick_q <= slow_wrap;
    end
  end

  // Slow divided by 64; two toggles per turn of the counter
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      square_cnt_q <= 6'h00;
      square_q     <= 1'b0;
    end
    else if (slow_tick_q)
    begin
      square_cnt_q <= square_cnt_q + 6'h01;
      if (square_flip)
        square_q <= ~square_q;
    end
  end

  // 1 Hz blink wave shared by both status pins
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      blink_cnt_q <= 10'h000;
      blink_q     <= 1'b0;
    end
    else if (slow_tick_q)
    begin
      blink_cnt_q <= blink_wrap ? 10'h000 : blink_cnt_q + 10'h001;
      if (blink_wrap)
        blink_q <= ~blink_q;
    end
  end

  // Start-up delay on fast / 4; stalls while the oscillator is stopped
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      pre_cnt_q     <= 2'h0;
      startup_cnt_q <= 16'h0000;
      ready_q       <= 1'b0;
    end
    else if (fast_tick_q && !ready_q)
    begin
      pre_cnt_q <= pre_cnt_q + 2'h1;
      if (pre_wrap)
      begin
        startup_cnt_q <= startup_cnt_q + 16'h0001;
        if (startup_done)
          ready_q <= 1'b1;
      end
    end
  end

  // Charge pump clock; a registered copy of the fast tick
  always_ff @(posedge clk)
  begin
    if (reset)
      pump_q <= 1'b0;
    else
      pump_q <= fast_tick_q;
  end

  // Read port; data trails the address by one cycle
  always_ff @(posedge clk)
  begin
    if (reset)
      rf_rdata_q <= 8'h00;
    else
      rf_rdata_q <= rf_pick;
  end

  // Reference bytes, one slice per entry; all sixteen are writable
  generate
    for (genvar b = 0; b < RF_BYTES; b++)
    begin : g_rf
      logic [7:0] init_byte;
      wire        hit = rf_write && (rf_addr == 4'(b));

      // Only the four reference bytes leave reset non-zero
      always_comb
      begin
        if (4'(b) == COIL_B_PEAK_REF_OFS)
          init_byte = COIL_B_PEAK_REF_RST;
        else if (4'(b) == COIL_B_HOLD_REF_OFS)
          init_byte = COIL_B_HOLD_REF_RST;
        else if (4'(b) == COIL_A_PEAK_REF_OFS)
          init_byte = COIL_A_PEAK_REF_RST;
        else if (4'(b) == COIL_A_HOLD_REF_OFS)
          init_byte = COIL_A_HOLD_REF_RST;
        else
          init_byte = 8'h00;
      end

      always_ff @(posedge clk)
      begin
        if (reset)
          rf_q[b] <= init_byte;
        else if (hit)
          rf_q[b] <= rf_wdata;
      end
    end
  endgenerate

  // Open-drain pin value is always low; only the enable moves
  always_ff @(posedge clk)
  begin
    if (reset)
      fault_pin_q <= 1'b0;
    else
      fault_pin_q <= 1'b0;
  end

  // Byte choice per channel; index 0 is coil A
  assign peak_ref[0] = rf_q[COIL_A_PEAK_REF_OFS];
  assign hold_ref[0] = rf_q[COIL_A_HOLD_REF_OFS];
  assign peak_ref[1] = rf_q[COIL_B_PEAK_REF_OFS];
  assign hold_ref[1] = rf_q[COIL_B_HOLD_REF_OFS];

  // Pins gathered per coil
  assign chan_in[0] = '{request: coil_request_a, fault: stage_fault_a, sense: sense_a};
  assign chan_in[1] = '{request: coil_request_b, fault: stage_fault_b, sense: sense_b};

  // Independent copies, one per coil
  generate
    for (genvar c = 0; c < 2; c++)
    begin : g_chan
      sphr_channel u_chan
      (
        .clk       (clk),
        .reset     (reset),
        .ready     (ready_q),
        .fast_tick (fast_tick_q),
        .slow_tick (slow_tick_q),
        .blink     (blink_q),
        .peak_ref  (peak_ref[c]),
        .hold_ref  (hold_ref[c]),
        .pin_in    (chan_in[c]),
        .pin_out   (chan_out[c])
      );
    end
  endgenerate

  // Pin map; every field is already a flop inside the channel
  assign high_side_out_a        = chan_out[0].high_side;
  assign low_side_out_a         = chan_out[0].low_side;
  assign stage_sleep_a          = chan_out[0].stage_sleep;
  assign output_drive_enable0_a = chan_out[0].drive_enable0;
  assign output_drive_enable1_a = chan_out[0].drive_enable1;
  assign status_out_a           = chan_out[0].status;
  assign fault_oe_n_a           = chan_out[0].fault_oe_n;
  assign fault_out_a            = fault_pin_q;

  assign high_side_out_b        = chan_out[1].high_side;
  assign low_side_out_b         = chan_out[1].low_side;
  assign stage_sleep_b          = chan_out[1].stage_sleep;
  assign output_drive_enable0_b = chan_out[1].drive_enable0;
  assign output_drive_enable1_b = chan_out[1].drive_enable1;
  assign status_out_b           = chan_out[1].status;
  assign fault_oe_n_b           = chan_out[1].fault_oe_n;
  assign fault_out_b            = fault_pin_q;
  assign ready                  = ready_q;
  assign charge_pump_clk        = pump_q;
  assign lf_square              = square_q;
  assign rf_rdata               = rf_rdata_q;

endmodule
